/* File: logic/agc_regs.svh */
/*
  register offsets, reset values, length units and last codes for the right agc timing block.
  assumes an 8-bit register port with byte offsets.
*/
`ifndef AGC_REGS_SVH
`define AGC_REGS_SVH
`define AGC_OFF_DECAY 8'h62
`define AGC_OFF_NOISE 8'h63
`define AGC_OFF_SIGNAL 8'h64
`define AGC_RST_DECAY 8'h00
`define AGC_RST_NOISE 5'h00
`define AGC_RST_SIGNAL 4'h0
`define AGC_DECAY_UNIT 32'd512
`define AGC_DEB_BASE 32'd4
`define AGC_NOISE_STEP 32'd4096
`define AGC_NOISE_LAST_DBL 5'h0B
`define AGC_SIG_LAST_CODE 4'h9
`endif

/* File: logic/agc_pkg.sv */
/*
  types for the right agc timing block.
  assumes agc_regs.svh holds the numeric constants.
*/
package agc_pkg;
  typedef struct packed {
    logic [4:0] base;
    logic [2:0] mult;
  } agc_decay_t;
  typedef struct packed {
    logic decay_done;
    logic noise_done;
    logic signal_done;
  } agc_flags_t;
  typedef enum logic [1:0] {AGC_IDLE, AGC_RUN, AGC_DONE} agc_state_t;
endpackage

/* File: logic/agc_timing.sv */
/*
  right agc timing: decay time and noise/signal debounce counters on the sample strobe.
  assumes an 8-bit register port on the system clock and that sample_tick, noise_detect,
  signal_detect and agc_enable come from logic on the same clock.
*/
// Operation
// - decay base is (2N+1) times 512 samples
// - decay scaled by two to the code
// - noise debounce doubles then steps by 4096
// - signal debounce doubles from four to 1024
// - reserved bits read zero, writes ignored
// - counters run only while agc enabled
`timescale 1ns/100ps
`include "agc_regs.svh"
module agc_timing import agc_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic agc_enable,
  input wire logic sample_tick,
  input wire logic decay_start,
  input wire logic noise_detect,
  input wire logic signal_detect,
  output agc_flags_t timing_flags
);
  agc_decay_t decay_reg;
  logic [4:0] noise_reg;
  logic [3:0] signal_reg;
  logic [31:0] decay_len, noise_len, signal_len;
  logic [31:0] decay_cnt_reg;
  logic decay_run_reg;
  logic decay_done_reg;
  logic cfg_chg;
  // debounce channels: index 0 is signal, index 1 is noise
  logic [1:0] deb_detect;
  logic [31:0] deb_len [2];
  logic [31:0] deb_cnt_reg [2];
  logic deb_done_reg [2];

  // doubling debounce: zero at code 0, else 4 << (code-1)
  function automatic logic [31:0] dbl_len(input logic [4:0] code);
    if (code == 5'h00) begin
      dbl_len = 32'd0;
    end else begin
      dbl_len = `AGC_DEB_BASE << (code - 5'h01);
    end
  endfunction

  // interval lengths in samples
  always_comb begin
    decay_len = ((32'({decay_reg.base, 1'b1})) * `AGC_DECAY_UNIT) << decay_reg.mult;
    if (noise_reg > `AGC_NOISE_LAST_DBL) begin
      noise_len = 32'(noise_reg - `AGC_NOISE_LAST_DBL + 5'h01) * `AGC_NOISE_STEP;
    end else begin
      noise_len = dbl_len(noise_reg);
    end
    if (signal_reg > `AGC_SIG_LAST_CODE) begin
      signal_len = dbl_len({1'b0, `AGC_SIG_LAST_CODE});
    end else begin
      signal_len = dbl_len({1'b0, signal_reg});
    end
  end

  // register writes; reserved bits are not stored
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      decay_reg <= `AGC_RST_DECAY;
      noise_reg <= `AGC_RST_NOISE;
      signal_reg <= `AGC_RST_SIGNAL;
    end else if (reg_wr) begin
      if (reg_addr == `AGC_OFF_DECAY) begin
        decay_reg <= reg_wdata;
      end else if (reg_addr == `AGC_OFF_NOISE) begin
        noise_reg <= reg_wdata[4:0];
      end else if (reg_addr == `AGC_OFF_SIGNAL) begin
        signal_reg <= reg_wdata[3:0];
      end
    end
  end

  // a write to any timing register clears the counters and stops a running decay
  assign cfg_chg = reg_wr && (reg_addr == `AGC_OFF_DECAY || reg_addr == `AGC_OFF_NOISE ||
                              reg_addr == `AGC_OFF_SIGNAL);

  // read mux, registered
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `AGC_OFF_DECAY) begin
      reg_rdata <= decay_reg;
    end else if (reg_addr == `AGC_OFF_NOISE) begin
      reg_rdata <= {3'h0, noise_reg};
    end else if (reg_addr == `AGC_OFF_SIGNAL) begin
      reg_rdata <= {4'h0, signal_reg};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // decay counter: started by decay_start, counts samples to decay_len;
  // the done flag is a one-cycle pulse so the gain loop takes one step
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      decay_cnt_reg <= 32'd0;
      decay_run_reg <= 1'b0;
      decay_done_reg <= 1'b0;
    end else if (!agc_enable || cfg_chg) begin
      decay_cnt_reg <= 32'd0;
      decay_run_reg <= 1'b0;
      decay_done_reg <= 1'b0;
    end else if (decay_start) begin
      decay_cnt_reg <= 32'd0;
      decay_run_reg <= 1'b1;
      decay_done_reg <= 1'b0;
    end else if (decay_run_reg && sample_tick) begin
      if (decay_cnt_reg + 32'd1 >= decay_len) begin
        decay_run_reg <= 1'b0;
        decay_done_reg <= 1'b1;
      end
      decay_cnt_reg <= decay_cnt_reg + 32'd1;
    end else begin
      decay_done_reg <= 1'b0;
    end
  end

  // detect levels and lengths gathered so both debounce channels share one body
  assign deb_detect = {noise_detect, signal_detect};
  assign deb_len[0] = signal_len;
  assign deb_len[1] = noise_len;

  // debounce: the detect level must hold for deb_len samples before the flag
  // rises; a drop of detect, a register write or a disable starts it over
  generate
    for (genvar g = 0; g < 2; g++) begin : g_deb
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          deb_cnt_reg[g] <= 32'd0;
          deb_done_reg[g] <= 1'b0;
        end else if (!agc_enable || cfg_chg || !deb_detect[g]) begin
          deb_cnt_reg[g] <= 32'd0;
          deb_done_reg[g] <= 1'b0;
        end else if (deb_cnt_reg[g] >= deb_len[g]) begin
          deb_done_reg[g] <= 1'b1;
        end else if (sample_tick) begin
          deb_cnt_reg[g] <= deb_cnt_reg[g] + 32'd1;
        end
      end
    end
  endgenerate

  // flags leave the block straight from their flip-flops, one driver for the struct
  assign timing_flags = '{decay_done: decay_done_reg, noise_done: deb_done_reg[1],
                          signal_done: deb_done_reg[0]};

  // disabled agc drops every flag and stops the counts
  a_dis_no_flags: assert property (@(posedge clock) disable iff (sys_rst)
    !agc_enable |=> timing_flags == 3'b000) else $error("flags while disabled");
  a_dis_decay_stop: assert property (@(posedge clock) disable iff (sys_rst)
    !agc_enable |=> !decay_run_reg) else $error("decay runs while disabled");
  a_dis_noise_clear: assert property (@(posedge clock) disable iff (sys_rst)
    !agc_enable |=> deb_cnt_reg[1] == 32'd0) else $error("noise count while disabled");

  // reserved bits of the debounce registers always read back as zero
  a_res_noise_zero: assert property (@(posedge clock) disable iff (sys_rst)
    reg_addr == `AGC_OFF_NOISE |=> reg_rdata[7:5] == 3'h0) else $error("noise rsvd");
  a_res_sig_zero: assert property (@(posedge clock) disable iff (sys_rst)
    reg_addr == `AGC_OFF_SIGNAL |=> reg_rdata[7:4] == 4'h0) else $error("signal rsvd");

  // decay length: odd base times 512, then shifted by the multiplier code
  a_decay_len_min: assert property (@(posedge clock) disable iff (sys_rst)
    decay_reg == 8'h00 |-> decay_len == 32'd512) else $error("decay min");
  a_decay_len_odd: assert property (@(posedge clock) disable iff (sys_rst)
    decay_reg == 8'h08 |-> decay_len == 32'd1536) else $error("decay odd base");
  a_decay_len_mult: assert property (@(posedge clock) disable iff (sys_rst)
    decay_reg == 8'h07 |-> decay_len == 32'd65536) else $error("decay mult");
  a_decay_len_max: assert property (@(posedge clock) disable iff (sys_rst)
    decay_reg == 8'hFF |-> decay_len == 32'd4128768) else $error("decay max");
  a_decay_one_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    timing_flags.decay_done |=> !timing_flags.decay_done) else $error("decay pulse");
  a_decay_tick_only: assert property (@(posedge clock) disable iff (sys_rst)
    decay_run_reg && !sample_tick && !decay_start && agc_enable && !cfg_chg |=>
    $stable(decay_cnt_reg)) else $error("decay count without tick");

  // noise debounce length: doubling up to 4096, then whole steps of 4096
  a_noise_len_min: assert property (@(posedge clock) disable iff (sys_rst)
    noise_reg == 5'h01 |-> noise_len == 32'd4) else $error("noise min");
  a_noise_len_dbl: assert property (@(posedge clock) disable iff (sys_rst)
    noise_reg == 5'h0B |-> noise_len == 32'd4096) else $error("noise last double");
  a_noise_len_step: assert property (@(posedge clock) disable iff (sys_rst)
    noise_reg == 5'h0C |-> noise_len == 32'd8192) else $error("noise first step");
  a_noise_len_top: assert property (@(posedge clock) disable iff (sys_rst)
    noise_reg == 5'h1F |-> noise_len == 32'd86016) else $error("noise top");
  a_noise_zero_code: assert property (@(posedge clock) disable iff (sys_rst)
    agc_enable && noise_detect && noise_reg == 5'h00 && !cfg_chg ##1
    agc_enable && noise_detect && !cfg_chg |=> timing_flags.noise_done)
    else $error("zero noise debounce");
  a_noise_drop_flag: assert property (@(posedge clock) disable iff (sys_rst)
    !noise_detect |=> !timing_flags.noise_done) else $error("noise flag without detect");

  // signal debounce length: doubling from four, held at 1024 above code 9
  a_sig_len_min: assert property (@(posedge clock) disable iff (sys_rst)
    signal_reg == 4'h1 |-> signal_len == 32'd4) else $error("signal min");
  a_sig_len_top: assert property (@(posedge clock) disable iff (sys_rst)
    signal_reg == 4'h9 |-> signal_len == 32'd1024) else $error("signal top");
  a_sig_len_clamp: assert property (@(posedge clock) disable iff (sys_rst)
    signal_reg > 4'h9 |-> signal_len == 32'd1024) else $error("signal clamp");
  a_sig_drop_flag: assert property (@(posedge clock) disable iff (sys_rst)
    !signal_detect |=> !timing_flags.signal_done) else $error("signal flag without detect");
  a_sig_hold_flag: assert property (@(posedge clock) disable iff (sys_rst)
    timing_flags.signal_done && signal_detect && agc_enable && !cfg_chg |=>
    timing_flags.signal_done) else $error("signal flag dropped");

  // any timing register write restarts both debounce counts
  a_cfg_restart: assert property (@(posedge clock) disable iff (sys_rst)
    cfg_chg |=> deb_cnt_reg[0] == 32'd0 && deb_cnt_reg[1] == 32'd0) else $error("reload");

  // main scenarios: each interval ends, long noise steps, clamped signal codes
  c_decay_done: cover property (@(posedge clock) disable iff (sys_rst) timing_flags.decay_done);
  c_noise_done: cover property (@(posedge clock) disable iff (sys_rst) timing_flags.noise_done);
  c_sig_done: cover property (@(posedge clock) disable iff (sys_rst) timing_flags.signal_done);
  c_noise_long: cover property (@(posedge clock) disable iff (sys_rst)
    timing_flags.noise_done && noise_reg > 5'h0B);
  c_sig_clamp: cover property (@(posedge clock) disable iff (sys_rst)
    timing_flags.signal_done && signal_reg > 4'h9);
endmodule // agc_timing

/* File: sim/right_agc_timing_test.sv */
/* bench for agc_timing: register readback and interval lengths against a model.
   assumes agc_regs.svh offsets and one sample_tick every second clock. */
`timescale 1ns/100ps
`include "agc_regs.svh"
module right_agc_timing_test;
  logic clock, sys_rst, reg_wr, agc_enable, sample_tick, decay_start;
  logic noise_detect, signal_detect;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  agc_pkg::agc_flags_t timing_flags;
  logic [7:0] mask [4] = '{8'hFF, 8'h1F, 8'h0F, 8'h00};
  int failures = 0, n_checks = 0, seed = 32'h0921, n;
  agc_timing dut (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .agc_enable(agc_enable),
    .sample_tick(sample_tick), .decay_start(decay_start), .noise_detect(noise_detect),
    .signal_detect(signal_detect), .timing_flags(timing_flags));
  // 125 MHz clock
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  // model of debounce lengths in sample periods
  function automatic int deb_len(int c, bit noise);
    if (c == 0) return 0;
    if (c <= (noise ? 11 : 9)) return 4 << (c - 1);
    return noise ? (c - 10) * 4096 : 1024;
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // register port cycles, entered just after an edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr = a;
    repeat (2) @(posedge clock);
    #1;
    chk(reg_rdata, exp);
  endtask
  // counts ticks given until the chosen flag shows, -1 if it never does
  task automatic measure(int which, int lim, output int cnt);
    int ticks = 0;
    cnt = -1;
    for (int i = 0; i < 2 * lim + 8 && cnt < 0; i++) begin
      @(posedge clock);
      #1;
      decay_start = 0;
      if (timing_flags[2 - which] === 1'b1) cnt = ticks;
      sample_tick = i[0] && cnt < 0 && i < 2 * lim + 7;
      ticks += sample_tick;
    end
  endtask
  task automatic run(int which, logic [7:0] val, int exp);
    wr(8'(`AGC_OFF_DECAY + which), val);
    decay_start = (which == 0);
    noise_detect = (which == 1);
    signal_detect = (which == 2);
    measure(which, exp, n);
    noise_detect = 0;
    signal_detect = 0;
    chk(n, exp);
  endtask
  // hang guard
  initial begin
    repeat (80000) @(posedge clock);
    failures++;
    finish_test;
  end
  initial begin
    {reg_wr, agc_enable, sample_tick, decay_start, noise_detect, signal_detect} = '0;
    reg_addr = 0;
    reg_wdata = 0;
    sys_rst = 1;
    repeat (12) @(posedge clock);
    #1;
    sys_rst = 0;
    // reset values, then random writes with reserved bits masked to zero, and an unmapped byte
    for (int a = 0; a < 4; a++) rd(8'(`AGC_OFF_DECAY + a), 8'h00);
    for (int k = 0; k < 12; k++) begin
      n = $random(seed);
      wr(8'(`AGC_OFF_DECAY + k % 4), n[7:0] & mask[k % 4]);
      rd(8'(`AGC_OFF_DECAY + k % 4), n[7:0] & mask[k % 4]);
    end
    // disabled agc: a short debounce never completes
    wr(`AGC_OFF_SIGNAL, 8'h01);
    signal_detect = 1;
    measure(2, 8, n);
    chk(n, -1);
    signal_detect = 0;
    agc_enable = 1;
    // decay base and multiplier: 512, 1536, 1024, 2048
    run(0, 8'h00, 512);
    run(0, 8'h08, 1536);
    run(0, 8'h01, 1024);
    run(0, 8'h02, 2048);
    for (int c = 0; c < 13; c++) run(1, 8'(c), deb_len(c, 1));
    for (int c = 0; c < 11; c++) run(2, 8'(c), deb_len(c, 0));
    finish_test;
  end
endmodule // right_agc_timing_test
